// ### rtl/data_transfer_opcode_decoder.sv
// byte-serial decoder for data-transfer instructions with minimum clock counts
// Behaviour
// [RULE1] 1000100w + modrm: register to reg/mem move, 2 or 12 clocks.
// [RULE2] 1000101w + modrm: reg/mem to register move, 2 or 9 clocks.
// [RULE3] 1100011w, reg 000, one or two data bytes: immediate to reg/mem, 12-13.
// [RULE4] 1011 w reg, data bytes per w: immediate to register, 3 or 4 clocks.
// [RULE5] 1010000w, address low/high: memory to accumulator, 8 clocks.
// [RULE6] 1010001w, address low/high: accumulator to memory, 9 clocks.
// [RULE7] 10001110, reg 0 seg: reg/mem to segment register, 2 or 9 clocks.
// [RULE8] 10001100, reg 0 seg: segment register to reg/mem, 2 or 11 clocks.
// [RULE9] 11111111 with reg 110: push memory operand, 16 clocks.
// [RULE10] 01010 reg: push general register, 10 clocks.
// [RULE11] 000 seg 110: push segment register, 9 clocks.
// [RULE12] 011010 s 0: push immediate, 10 clocks, second byte only if s clear.
// [RULE13] 01100000: save all registers on stack, 36 clocks minimum.
// [RULE14] 10001111 with reg 000: pop into memory, 20 clocks.
// [RULE15] 01011 reg: pop into general register, 10 clocks.
// [RULE16] 000 seg 111: pop into segment register, 8 clocks; segment 01 excluded.
// [RULE17] 01100001: restore all registers from stack, 51 clocks minimum.
// [RULE18] 1000011w + modrm: exchange register with reg/mem, 4 or 17 clocks.
// [RULE19] width bit 0 means byte, 1 means word; sets width and immediate length.
// [RULE20] two counts: first for register operand, second for memory operand.
module data_transfer_opcode_decoder
   import xfer_decode_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // prefetched instruction bytes
   input  wire logic [7:0] byteData,
   input  wire logic       byteValid,
   output logic            byteReady,
   // decoded instruction
   output logic            insnValid,
   output insn_class_t     insnClass,
   output logic            insnWide,
   output logic            insnMem,
   output logic [2:0]      insnRegNo,
   output logic [7:0]      insnModRm,
   output logic [15:0]     insnImm,
   output logic [15:0]     insnAddr,
   output logic [5:0]      insnClocks,
   output logic            insnIllegal,
   // completion from execution side
   input  wire logic       insnTaken
);

   // ----------------------------------------
   // fetch sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_MODRM,
      ST_DISP,
      ST_TAIL,
      ST_HOLD
   } fetch_state_t;

   fetch_state_t stateReg, stateNext;
   logic [7:0]   opReg;
   logic [7:0]   modRmReg;
   logic [1:0]   dispLeftReg;
   logic [1:0]   tailLeftReg;
   logic         tailIsAddrReg;
   logic [15:0]  tailDataReg;
   logic         tailHiReg;

   // classification of the opcode byte on the bus or the latched one
   wire          inOpcode   = stateReg == ST_OPCODE;
   wire [7:0]    opSel      = inOpcode ? byteData : opReg;
   wire [7:0]    modRmSel   = (stateReg == ST_MODRM) ? byteData : modRmReg;
   insn_class_t  clsW;
   wire          needsModRmW;
   wire          wideW;
   wire [1:0]    immBytesW;
   wire [1:0]    addrBytesW;

   first_byte_classifier u_classify (
      .opByte     (opSel),
      .modRmByte  (modRmSel),
      .insnClass  (clsW),
      .needsModRm (needsModRmW),
      .isWide     (wideW),
      .immBytes   (immBytesW),
      .addrBytes  (addrBytesW)
   );

   // mod field 11 picks a register, anything else memory
   wire          memW       = needsModRmW && (modRmSel[7:6] != MOD_REGISTER);     // RULE20
   wire [1:0]    dispBytesW = !memW ? 2'd0 :
                              (modRmSel[7:6] == 2'd2) ? 2'd2 :
                              (modRmSel[7:6] == 2'd1) ? 2'd1 :
                              (modRmSel[2:0] == 3'd6) ? 2'd2 : 2'd0;
   wire [5:0]    clocksW;

   clock_count_table u_clocks (
      .insnClass  (clsW),
      .memOperand (memW),
      .isWide     (wideW),
      .clocks     (clocksW)
   );

   wire          byteFire   = byteValid && byteReady;
   wire [1:0]    tailW      = immBytesW + addrBytesW;
   wire          holdDone   = insnValid && insnTaken;
   wire          lastTail   = tailLeftReg == 2'd1;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      stateNext = stateReg;
      unique case (stateReg)
         ST_OPCODE: begin
            if (byteFire) begin
               if (needsModRmW)
                  stateNext = ST_MODRM;
               else if (tailW != 2'd0)
                  stateNext = ST_TAIL;
               else
                  stateNext = ST_HOLD;
            end
         end
         ST_MODRM: begin
            if (byteFire) begin
               if (dispBytesW != 2'd0)
                  stateNext = ST_DISP;
               else if (tailW != 2'd0)
                  stateNext = ST_TAIL;
               else
                  stateNext = ST_HOLD;
            end
         end
         ST_DISP: begin
            if (byteFire && dispLeftReg == 2'd1)
               stateNext = (tailW != 2'd0) ? ST_TAIL : ST_HOLD;
         end
         ST_TAIL: begin
            if (byteFire && lastTail)
               stateNext = ST_HOLD;
         end
         ST_HOLD: begin
            if (holdDone)
               stateNext = ST_OPCODE;
         end
         default: stateNext = ST_OPCODE;
      endcase
   end

   // ----------------------------------------
   // byte latches
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         stateReg  <= ST_OPCODE;
         byteReady <= 1'b1;
         opReg     <= 8'h00;
         modRmReg  <= 8'h00;
      end else begin
         stateReg  <= stateNext;
         // registered copy of the hold decode, so the queue sees a clean level
         byteReady <= stateNext != ST_HOLD;
         if (byteFire && inOpcode)
            opReg <= byteData;
         if (byteFire && stateReg == ST_MODRM)
            modRmReg <= byteData;
      end
   end

   // displacement bytes are consumed but not kept; the address unit owns them
   always_ff @(posedge clk) begin
      if (srst) begin
         dispLeftReg <= 2'd0;
      end else if (byteFire && stateReg == ST_MODRM) begin
         dispLeftReg <= dispBytesW;
      end else if (byteFire && stateReg == ST_DISP) begin
         dispLeftReg <= dispLeftReg - 2'd1;
      end
   end

   // immediate or direct address, low byte first
   always_ff @(posedge clk) begin
      if (srst) begin
         tailLeftReg   <= 2'd0;
         tailIsAddrReg <= 1'b0;
         tailDataReg   <= 16'h0000;
         tailHiReg     <= 1'b0;
      end else if (byteFire && (inOpcode || stateReg == ST_MODRM)) begin
         tailLeftReg   <= tailW;                                         // RULE3 RULE4 RULE12
         tailIsAddrReg <= addrBytesW != 2'd0;                            // RULE5 RULE6
         tailDataReg   <= 16'h0000;
         tailHiReg     <= 1'b0;
      end else if (byteFire && stateReg == ST_TAIL) begin
         tailLeftReg <= tailLeftReg - 2'd1;
         tailHiReg   <= 1'b1;
         if (tailHiReg)
            tailDataReg[15:8] <= byteData;
         else
            tailDataReg <= {{8{byteData[7]}}, byteData};                 // RULE12
      end
   end

   // ----------------------------------------
   // decoded outputs
   // ----------------------------------------
   wire          finishing = byteFire && stateNext == ST_HOLD;
   wire [15:0]   tailFinal = (stateReg != ST_TAIL) ? tailDataReg :
                             tailHiReg ? {byteData, tailDataReg[7:0]} :
                             {{8{byteData[7]}}, byteData};
   wire          zeroExt   = !wideW && !tailIsAddrReg;                   // RULE19
   wire [15:0]   immFinal  = zeroExt ? {8'h00, tailFinal[7:0]} : tailFinal;
   wire [2:0]    regNoW    = needsModRmW ? modRmSel[5:3] :
                             (clsW == CLS_PUSH_SEG || clsW == CLS_POP_SEG) ? {1'b0, opSel[4:3]} :
                             opSel[2:0];

   always_ff @(posedge clk) begin
      if (srst) begin
         insnValid   <= 1'b0;
         insnClass   <= CLS_NONE;
         insnWide    <= 1'b0;
         insnMem     <= 1'b0;
         insnRegNo   <= 3'h0;
         insnModRm   <= 8'h00;
         insnImm     <= 16'h0000;
         insnAddr    <= 16'h0000;
         insnClocks  <= 6'h00;
         insnIllegal <= 1'b0;
      end else if (finishing) begin
         insnValid   <= 1'b1;
         insnClass   <= clsW;
         insnWide    <= wideW;                                           // RULE19
         insnMem     <= memW | (addrBytesW != 2'd0);
         insnRegNo   <= regNoW;
         insnModRm   <= needsModRmW ? modRmSel : 8'h00;
         insnImm     <= tailIsAddrReg ? 16'h0000 : immFinal;
         insnAddr    <= tailIsAddrReg ? tailFinal : 16'h0000;            // RULE5 RULE6
         insnClocks  <= clocksW;                                         // RULE20
         insnIllegal <= clsW == CLS_NONE;
      end else if (holdDone) begin
         insnValid <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence single_byte_s(logic [7:0] pat);
      stateReg == ST_OPCODE && byteFire && byteData == pat;
   endsequence

   push_all_count_a: assert property (@(posedge clk) disable iff (srst)   // RULE13
      single_byte_s(OPC_PUSH_ALL) |=> insnValid && insnClocks == 6'd36 && insnClass == CLS_PUSH_ALL)
      else $error("save-all count wrong");
   pop_all_count_a: assert property (@(posedge clk) disable iff (srst)    // RULE17
      single_byte_s(OPC_POP_ALL) |=> insnValid && insnClocks == 6'd51)
      else $error("restore-all count wrong");
   push_reg_count_a: assert property (@(posedge clk) disable iff (srst)   // RULE10
      stateReg == ST_OPCODE && byteFire && byteData[7:3] == 5'h0A
      |=> insnClass == CLS_PUSH_R && insnClocks == 6'd10 && insnRegNo == $past(byteData[2:0]))
      else $error("register push decode wrong");
   pop_reg_count_a: assert property (@(posedge clk) disable iff (srst)    // RULE15
      stateReg == ST_OPCODE && byteFire && byteData[7:3] == 5'h0B |=> insnClocks == 6'd10)
      else $error("register pop count wrong");
   pop_seg_excl_a: assert property (@(posedge clk) disable iff (srst)     // RULE16
      single_byte_s(8'h0F) |=> insnIllegal)
      else $error("excluded segment pop accepted");
   push_seg_count_a: assert property (@(posedge clk) disable iff (srst)   // RULE11
      single_byte_s(8'h1E) |=> insnClocks == 6'd9 && insnRegNo == 3'h3)
      else $error("segment push decode wrong");
   // last address byte of an accumulator load; stalls of the queue may come before it
   sequence acc_load_last_s;
      stateReg == ST_TAIL && byteFire && lastTail && opReg[7:1] == OPC_MOV_M_ACC;
   endsequence

   acc_load_walk_a: assert property (@(posedge clk) disable iff (srst)    // RULE5
      acc_load_last_s
      |=> insnValid && insnClocks == 6'd8 && insnAddr == {$past(byteData), tailDataReg[7:0]})
      else $error("accumulator load wrong");
   exchange_operands_reg_count_a: assert property (@(posedge clk) disable iff (srst)   // RULE18 RULE20
      stateReg == ST_MODRM && byteFire && opReg[7:1] == 7'h43 && byteData[7:6] == 2'h3
      |=> insnClocks == 6'd4 && !insnMem)
      else $error("register exchange count wrong");
   mov_mem_count_a: assert property (@(posedge clk) disable iff (srst)    // RULE1
      insnValid && insnClass == CLS_MOV_R_RM |-> insnClocks == (insnMem ? 6'd12 : 6'd2))
      else $error("register store count wrong");
   hold_stable_a: assert property (@(posedge clk) disable iff (srst)      // RULE19
      insnValid && !insnTaken |=> insnValid && $stable(insnClass) && $stable(insnImm))
      else $error("decoded result changed while held");

endmodule : data_transfer_opcode_decoder

// ### rtl/xfer_decode_pkg.sv
// constants for the data-transfer opcode decoder
package xfer_decode_pkg;

   // ----------------------------------------
   // instruction classes
   // ----------------------------------------
   typedef enum logic [4:0] {
      CLS_NONE,
      CLS_MOV_R_RM,
      CLS_MOV_RM_R,
      CLS_MOV_I_RM,
      CLS_MOV_I_R,
      CLS_MOV_M_ACC,
      CLS_MOV_ACC_M,
      CLS_MOV_RM_SEG,
      CLS_MOV_SEG_RM,
      CLS_PUSH_M,
      CLS_PUSH_R,
      CLS_PUSH_SEG,
      CLS_PUSH_I,
      CLS_PUSH_ALL,
      CLS_POP_M,
      CLS_POP_R,
      CLS_POP_SEG,
      CLS_POP_ALL,
      CLS_EXCHANGE_OPERANDS_RM
   } insn_class_t;

   // ----------------------------------------
   // opcode patterns
   // ----------------------------------------
   localparam logic [6:0] OPC_MOV_R_RM   = 7'h44;
   localparam logic [6:0] OPC_MOV_RM_R   = 7'h45;
   localparam logic [6:0] OPC_MOV_I_RM   = 7'h63;
   localparam logic [3:0] OPC_MOV_I_R    = 4'hB;
   localparam logic [6:0] OPC_MOV_M_ACC  = 7'h50;
   localparam logic [6:0] OPC_MOV_ACC_M  = 7'h51;
   localparam logic [7:0] OPC_MOV_RM_SEG = 8'h8E;
   localparam logic [7:0] OPC_MOV_SEG_RM = 8'h8C;
   localparam logic [7:0] OPC_GRP_FF     = 8'hFF;
   localparam logic [4:0] OPC_PUSH_R     = 5'h0A;
   localparam logic [4:0] OPC_POP_R      = 5'h0B;
   localparam logic [2:0] OPC_SEG_HI     = 3'h0;
   localparam logic [2:0] OPC_PUSH_SEG_LO = 3'h6;
   localparam logic [2:0] OPC_POP_SEG_LO  = 3'h7;
   localparam logic [5:0] OPC_PUSH_I     = 6'h1A;
   localparam logic [7:0] OPC_PUSH_ALL   = 8'h60;
   localparam logic [7:0] OPC_POP_ALL    = 8'h61;
   localparam logic [7:0] OPC_POP_M      = 8'h8F;
   localparam logic [6:0] OPC_EXCHANGE_OPERANDS_RM    = 7'h43;

   localparam logic [2:0] REG_FIELD_ZERO = 3'h0;
   localparam logic [2:0] REG_FIELD_PUSH = 3'h6;
   localparam logic [1:0] SEG_NO_POP     = 2'h1;
   localparam logic [1:0] MOD_REGISTER   = 2'h3;

   // ----------------------------------------
   // minimum clock counts
   // ----------------------------------------
   localparam logic [5:0] CLK_MOV_R_RM_R   = 6'd2;
   localparam logic [5:0] CLK_MOV_R_RM_M   = 6'd12;
   localparam logic [5:0] CLK_MOV_RM_R_R   = 6'd2;
   localparam logic [5:0] CLK_MOV_RM_R_M   = 6'd9;
   localparam logic [5:0] CLK_MOV_I_RM_R   = 6'd12;
   localparam logic [5:0] CLK_MOV_I_RM_M   = 6'd13;
   localparam logic [5:0] CLK_MOV_I_R_B    = 6'd3;
   localparam logic [5:0] CLK_MOV_I_R_W    = 6'd4;
   localparam logic [5:0] CLK_MOV_M_ACC    = 6'd8;
   localparam logic [5:0] CLK_MOV_ACC_M    = 6'd9;
   localparam logic [5:0] CLK_MOV_RM_SEG_R = 6'd2;
   localparam logic [5:0] CLK_MOV_RM_SEG_M = 6'd9;
   localparam logic [5:0] CLK_MOV_SEG_RM_R = 6'd2;
   localparam logic [5:0] CLK_MOV_SEG_RM_M = 6'd11;
   localparam logic [5:0] CLK_PUSH_M       = 6'd16;
   localparam logic [5:0] CLK_PUSH_R       = 6'd10;
   localparam logic [5:0] CLK_PUSH_SEG     = 6'd9;
   localparam logic [5:0] CLK_PUSH_I       = 6'd10;
   localparam logic [5:0] CLK_PUSH_ALL     = 6'd36;
   localparam logic [5:0] CLK_POP_M        = 6'd20;
   localparam logic [5:0] CLK_POP_R        = 6'd10;
   localparam logic [5:0] CLK_POP_SEG      = 6'd8;
   localparam logic [5:0] CLK_POP_ALL      = 6'd51;
   localparam logic [5:0] CLK_EXCHANGE_OPERANDS_R       = 6'd4;
   localparam logic [5:0] CLK_EXCHANGE_OPERANDS_M       = 6'd17;

endpackage : xfer_decode_pkg

// ### rtl/first_byte_classifier.sv
// combinational classification of an opcode byte and its optional addressing byte
module first_byte_classifier
   import xfer_decode_pkg::*;
(
   // opcode and addressing byte
   input  wire logic [7:0] opByte,
   input  wire logic [7:0] modRmByte,
   // classification
   output insn_class_t     insnClass,
   output logic            needsModRm,
   output logic            isWide,
   output logic [1:0]      immBytes,
   output logic [1:0]      addrBytes
);

   wire [2:0] regField = modRmByte[5:3];
   wire       wBit     = opByte[0];

   wire isMovRRm   = opByte[7:1] == OPC_MOV_R_RM;
   wire isMovRmR   = opByte[7:1] == OPC_MOV_RM_R;
   wire isMovIRm   = opByte[7:1] == OPC_MOV_I_RM;
   wire isMovIR    = opByte[7:4] == OPC_MOV_I_R;
   wire isMovMAcc  = opByte[7:1] == OPC_MOV_M_ACC;
   wire isMovAccM  = opByte[7:1] == OPC_MOV_ACC_M;
   wire isMovRmSeg = opByte == OPC_MOV_RM_SEG;
   wire isMovSegRm = opByte == OPC_MOV_SEG_RM;
   wire isGrpFf    = opByte == OPC_GRP_FF;
   wire isPushR    = opByte[7:3] == OPC_PUSH_R;
   wire isPopR     = opByte[7:3] == OPC_POP_R;
   wire isPushSeg  = opByte[7:5] == OPC_SEG_HI && opByte[2:0] == OPC_PUSH_SEG_LO;
   wire isPopSeg   = opByte[7:5] == OPC_SEG_HI && opByte[2:0] == OPC_POP_SEG_LO
                     && opByte[4:3] != SEG_NO_POP;
   wire isPushI    = opByte[7:2] == OPC_PUSH_I && !opByte[0];
   wire isPushAll  = opByte == OPC_PUSH_ALL;
   wire isPopAll   = opByte == OPC_POP_ALL;
   wire isPopM     = opByte == OPC_POP_M;
   wire isXchg     = opByte[7:1] == OPC_EXCHANGE_OPERANDS_RM;

   // the reg-field checks need the second byte; needsModRm lets the caller know it matters
   always_comb begin
      insnClass = CLS_NONE;
      if (isMovRRm)                                      insnClass = CLS_MOV_R_RM;   // RULE1
      else if (isMovRmR)                                 insnClass = CLS_MOV_RM_R;   // RULE2
      else if (isMovIRm && regField == REG_FIELD_ZERO)   insnClass = CLS_MOV_I_RM;   // RULE3
      else if (isMovIR)                                  insnClass = CLS_MOV_I_R;    // RULE4
      else if (isMovMAcc)                                insnClass = CLS_MOV_M_ACC;  // RULE5
      else if (isMovAccM)                                insnClass = CLS_MOV_ACC_M;  // RULE6
      else if (isMovRmSeg && !regField[2])               insnClass = CLS_MOV_RM_SEG; // RULE7
      else if (isMovSegRm && !regField[2])               insnClass = CLS_MOV_SEG_RM; // RULE8
      else if (isGrpFf && regField == REG_FIELD_PUSH)    insnClass = CLS_PUSH_M;     // RULE9
      else if (isPushR)                                  insnClass = CLS_PUSH_R;     // RULE10
      else if (isPushSeg)                                insnClass = CLS_PUSH_SEG;   // RULE11
      else if (isPushI)                                  insnClass = CLS_PUSH_I;     // RULE12
      else if (isPushAll)                                insnClass = CLS_PUSH_ALL;   // RULE13
      else if (isPopM && regField == REG_FIELD_ZERO)     insnClass = CLS_POP_M;      // RULE14
      else if (isPopR)                                   insnClass = CLS_POP_R;      // RULE15
      else if (isPopSeg)                                 insnClass = CLS_POP_SEG;    // RULE16
      else if (isPopAll)                                 insnClass = CLS_POP_ALL;    // RULE17
      else if (isXchg)                                   insnClass = CLS_EXCHANGE_OPERANDS_RM;    // RULE18
   end

   assign needsModRm = isMovRRm | isMovRmR | isMovIRm | isMovRmSeg | isMovSegRm
                       | isGrpFf | isPopM | isXchg;

   // push-immediate has no width bit: it is always a word push
   assign isWide = isMovIR ? opByte[3] : (isPushI | isPushAll | isPopAll | isPushR | isPopR
                   | isPushSeg | isPopSeg | isGrpFf | isPopM | isMovRmSeg | isMovSegRm) ? 1'b1
                   : wBit;   // RULE19

   assign immBytes  = isMovIRm ? (wBit ? 2'd2 : 2'd1) :                       // RULE3 RULE19
                      isMovIR  ? (opByte[3] ? 2'd2 : 2'd1) :                  // RULE4
                      isPushI  ? (opByte[1] ? 2'd1 : 2'd2) : 2'd0;            // RULE12
   assign addrBytes = (isMovMAcc | isMovAccM) ? 2'd2 : 2'd0;                  // RULE5 RULE6

endmodule : first_byte_classifier

// ### rtl/clock_count_table.sv
// minimum execution clock counts per instruction class
module clock_count_table
   import xfer_decode_pkg::*;
(
   // selection
   input  insn_class_t     insnClass,
   input  wire logic       memOperand,
   input  wire logic       isWide,
   // result
   output logic [5:0]      clocks
);

   // first figure of a pair is the register form, second the memory form
   always_comb begin
      unique case (insnClass)
         CLS_MOV_R_RM:   clocks = memOperand ? CLK_MOV_R_RM_M : CLK_MOV_R_RM_R;     // RULE1 RULE20
         CLS_MOV_RM_R:   clocks = memOperand ? CLK_MOV_RM_R_M : CLK_MOV_RM_R_R;     // RULE2 RULE20
         CLS_MOV_I_RM:   clocks = memOperand ? CLK_MOV_I_RM_M : CLK_MOV_I_RM_R;     // RULE3 RULE20
         CLS_MOV_I_R:    clocks = isWide ? CLK_MOV_I_R_W : CLK_MOV_I_R_B;           // RULE4
         CLS_MOV_M_ACC:  clocks = CLK_MOV_M_ACC;                                    // RULE5
         CLS_MOV_ACC_M:  clocks = CLK_MOV_ACC_M;                                    // RULE6
         CLS_MOV_RM_SEG: clocks = memOperand ? CLK_MOV_RM_SEG_M : CLK_MOV_RM_SEG_R; // RULE7
         CLS_MOV_SEG_RM: clocks = memOperand ? CLK_MOV_SEG_RM_M : CLK_MOV_SEG_RM_R; // RULE8
         CLS_PUSH_M:     clocks = CLK_PUSH_M;                                       // RULE9
         CLS_PUSH_R:     clocks = CLK_PUSH_R;                                       // RULE10
         CLS_PUSH_SEG:   clocks = CLK_PUSH_SEG;                                     // RULE11
         CLS_PUSH_I:     clocks = CLK_PUSH_I;                                       // RULE12
         CLS_PUSH_ALL:   clocks = CLK_PUSH_ALL;                                     // RULE13
         CLS_POP_M:      clocks = CLK_POP_M;                                        // RULE14
         CLS_POP_R:      clocks = CLK_POP_R;                                        // RULE15
         CLS_POP_SEG:    clocks = CLK_POP_SEG;                                      // RULE16
         CLS_POP_ALL:    clocks = CLK_POP_ALL;                                      // RULE17
         CLS_EXCHANGE_OPERANDS_RM:    clocks = memOperand ? CLK_EXCHANGE_OPERANDS_M : CLK_EXCHANGE_OPERANDS_R;             // RULE18 RULE20
         default:        clocks = 6'h00;
      endcase
   end

endmodule : clock_count_table

// ### tb/prefetch_queue_model.sv
// behavioural prefetch queue offering instruction bytes to the decoder
module prefetch_queue_model (
   // byte handshake with the decoder
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       byteReady,
   output logic [7:0]      byteData,
   output logic            byteValid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] fifo[$];
   logic       took = 1'b0;
   int         seed = 3;
   initial byteValid = 1'b0;
   initial byteData = 8'h00;
   always @(posedge clk) took <= byteValid && byteReady && !srst;
   // an offered byte stands until taken; idle cycles toggle the data so a stale byte never looks fresh
   always @(negedge clk) begin
      if (took) void'(fifo.pop_front());
      if (took || !byteValid) begin
         byteValid = fifo.size() > 0 && $random(seed) % 3 != 0;
         byteData = byteValid ? fifo[0] : ~byteData;
      end
   end
endmodule : prefetch_queue_model

// ### tb/data_transfer_opcode_decoder_tb_top.sv
// self-checking bench for the data-transfer opcode decoder
module data_transfer_opcode_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import xfer_decode_pkg::*;
   logic        clk, srst, byteValid, byteReady, insnValid, insnWide, insnMem, insnIllegal, insnTaken, w;
   logic [7:0]  byteData, insnModRm;
   logic [15:0] insnImm, insnAddr, d;
   logic [5:0]  insnClocks;
   logic [2:0]  insnRegNo, rg;
   logic [1:0]  md;
   insn_class_t insnClass;
   int          n_errors = 0, check_count = 0, seed = 3;
   data_transfer_opcode_decoder i_data_transfer_opcode_decoder (.*);
   prefetch_queue_model i_prefetch_queue_model (.*);
   task automatic check(input string what, input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // word forms: the w bit where the opcode has one, bit 3 for immediate-to-register, else always word
   function automatic logic exp_wide(input logic [7:0] op, input insn_class_t c);
      if (c == CLS_MOV_I_R) return op[3];
      return (c inside {CLS_MOV_R_RM, CLS_MOV_RM_R, CLS_MOV_I_RM, CLS_MOV_M_ACC, CLS_MOV_ACC_M, CLS_EXCHANGE_OPERANDS_RM})
             ? op[0] : 1'b1;
   endfunction : exp_wide
   function automatic logic [2:0] exp_reg(input logic [7:0] op, input insn_class_t c, input logic mr,
                                          input logic [2:0] rf);
      if (mr) return rf;
      if (c == CLS_PUSH_SEG || c == CLS_POP_SEG) return {1'b0, op[4:3]};
      return op[2:0];
   endfunction : exp_reg
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic put(input logic [7:0] b);
      i_prefetch_queue_model.fifo.push_back(b);
   endtask : put
   // r/m stays at 110 so that mod 00 takes the direct-address path with two extra bytes
   task automatic run(input logic [7:0] op, input insn_class_t c, input logic [5:0] r, m = 6'h0,
                      input logic mr = 1'b0, input logic [2:0] rf = 3'h0, input int n = 0,
                      input logic [15:0] v = 16'h0);
      int t = 0;
      put(op);
      if (mr) put({md, rf, 3'h6});
      if (mr && md != 2'h3) put(8'h5A);
      if (mr && !md[0]) put(8'hA5);
      if (n > 0) put(v[7:0]);
      if (n > 1) put(v[15:8]);
      while (insnValid !== 1'b1 && t++ < 100) @(negedge clk);
      if (t > 100) n_errors++;
      check("class", 16'(insnClass), 16'(c));
      check("ready", 16'(byteReady), 16'h0);
      check("illegal", 16'(insnIllegal), 16'(c == CLS_NONE));
      if (c != CLS_NONE) begin
         check("clocks", 16'(insnClocks), 16'((mr && md != 2'h3) ? m : r));
         if (n > 0) check("value", (n == 3) ? insnAddr : insnImm, v);
         if (mr) check("mem", 16'(insnMem), 16'(md != 2'h3));
         if (mr) check("modrm", 16'(insnModRm), 16'({md, rf, 3'h6}));
         check("wide", 16'(insnWide), 16'(exp_wide(op, c)));
         check("regno", 16'(insnRegNo), 16'(exp_reg(op, c, mr, rf)));
      end
      insnTaken = 1'b1;
      @(negedge clk);
      insnTaken = 1'b0;
   endtask : run
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #300000 n_errors++;
      close_out();
   end
   initial begin
      srst = 1'b1;
      insnTaken = 1'b0;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      repeat (24) begin
         {md, rg, w, d} = 22'($random(seed));
         run({7'h44, w}, CLS_MOV_R_RM, 6'h2, 6'hC, 1'b1, rg);
         run({7'h45, w}, CLS_MOV_RM_R, 6'h2, 6'h9, 1'b1, rg);
         run({7'h63, w}, CLS_MOV_I_RM, 6'hC, 6'hD, 1'b1, 3'h0, w ? 2 : 1, w ? d : {8'h0, d[7:0]});
         run({4'hB, w, rg}, CLS_MOV_I_R, w ? 6'h4 : 6'h3, 6'h0, 1'b0, 3'h0, w ? 2 : 1, w ? d : {8'h0, d[7:0]});
         run({7'h50, w}, CLS_MOV_M_ACC, 6'h8, 6'h0, 1'b0, 3'h0, 3, d);
         run({7'h51, w}, CLS_MOV_ACC_M, 6'h9, 6'h0, 1'b0, 3'h0, 3, d);
         run(8'h8E, CLS_MOV_RM_SEG, 6'h2, 6'h9, 1'b1, {1'b0, rg[1:0]});
         run(8'h8C, CLS_MOV_SEG_RM, 6'h2, 6'hB, 1'b1, {1'b0, rg[1:0]});
         run(8'hFF, CLS_PUSH_M, 6'h10, 6'h10, 1'b1, 3'h6);
         run({5'h0A, rg}, CLS_PUSH_R, 6'hA);
         run({3'h0, rg[1:0], 3'h6}, CLS_PUSH_SEG, 6'h9);
         run({6'h1A, w, 1'b0}, CLS_PUSH_I, 6'hA, 6'h0, 1'b0, 3'h0, w ? 1 : 2, w ? {{8{d[7]}}, d[7:0]} : d);
         run(8'h60, CLS_PUSH_ALL, 6'h24);
         run(8'h8F, CLS_POP_M, 6'h14, 6'h14, 1'b1);
         run({5'h0B, rg}, CLS_POP_R, 6'hA);
         run({3'h0, rg[1:0], 3'h7}, (rg[1:0] == 2'h1) ? CLS_NONE : CLS_POP_SEG, 6'h8);
         run(8'h61, CLS_POP_ALL, 6'h33);
         run({7'h43, w}, CLS_EXCHANGE_OPERANDS_RM, 6'h4, 6'h11, 1'b1, rg);
         md = 2'h3;
         run(8'hFF, CLS_NONE, 6'h0, 6'h0, 1'b1, rg | 3'h1);
         run(8'h8E, CLS_NONE, 6'h0, 6'h0, 1'b1, {1'b1, rg[1:0]});
      end
      close_out();
   end
endmodule : data_transfer_opcode_decoder_tb_top
